// ---- inc/btsu_regs.svh ----
// Constants for the block transfer and swap unit
`ifndef BTSU_REGS_SVH
`define BTSU_REGS_SVH
// ==========================================================
// Register offsets (byte addresses on the register bus)
`define BTSU_CTRL_OFS 8'h00
`define BTSU_STATUS_OFS 8'h04
`define BTSU_CYCLES_OFS 8'h08
// ==========================================================
// Control fields and reset value
`define BTSU_CTRL_EN_BIT 0
`define BTSU_CTRL_BIG_BIT 1
`define BTSU_CTRL_RESET 2'h1
// ==========================================================
// Instruction field positions
`define BTSU_P_BIT 24
`define BTSU_U_BIT 23
`define BTSU_S_BIT 22
`define BTSU_W_BIT 21
`define BTSU_L_BIT 20
`define BTSU_BLK_CLASS 3'h4
`define BTSU_SWP_CLASS 5'h02
`define BTSU_SWP_MARK 8'h09
// ==========================================================
// Fixed values
`define BTSU_PC_IDX 4'hF
`define BTSU_PC_STORE_OFS 32'h0000000C
`define BTSU_WORD_STEP 32'h00000004
`define BTSU_RESP_OKAY 2'h0
`define BTSU_RESP_DECERR 2'h3
`endif

// ---- inc/btsu_pkg.sv ----
// Types shared by the block transfer and swap unit
package btsu_pkg;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CALC = 4'b0001,
        ST_XFER = 4'b0010,
        ST_FIN = 4'b0011,
        ST_PCF1 = 4'b0100,
        ST_PCF2 = 4'b0101,
        ST_SWRD = 4'b0110,
        ST_SWWR = 4'b0111,
        ST_SWFIN = 4'b1000
    } btsu_state_t;
    // Bus cycle kinds shown on the memory side
    typedef enum logic [1:0] {
        CYC_N = 2'b00,
        CYC_S = 2'b01,
        CYC_I = 2'b10
    } btsu_cyc_t;
endpackage : btsu_pkg

// ---- src/btsu_popcnt.sv ----
// Counts the set bits of a register list
`timescale 1ns/100ps
`default_nettype none
module btsu_popcnt #(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] mask,
    output logic [4:0] count
);
    // ==========================================================
    // Ones count
    always_comb begin
        count = 5'h00;
        for (int i = 0; i < WIDTH; i++) begin
            count = count + {4'h0, mask[i]};
        end
    end
endmodule : btsu_popcnt
`default_nettype wire

// ---- src/btsu_lowbit.sv ----
// Finds the lowest set bit of a register list
`timescale 1ns/100ps
`default_nettype none
module btsu_lowbit #(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] mask,
    output logic [3:0] index
);
    // ==========================================================
    // Scan from the top so the lowest set bit wins
    always_comb begin
        index = 4'h0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (mask[i]) begin
                index = 4'(i);
            end
        end
    end
endmodule : btsu_lowbit
`default_nettype wire

// ---- src/btsu_core.sv ----
// Sequencer for load-multiple, store-multiple and atomic swap
`include "btsu_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module btsu_core (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] instr_addr,
    output logic instr_ready,
    output logic [3:0] rf_rd_idx,
    output logic rf_rd_user,
    input wire logic [31:0] rf_rd_data,
    output logic [3:0] rf_base_idx,
    input wire logic [31:0] rf_base_data,
    output logic rf_wr_en,
    output logic [3:0] rf_wr_idx,
    output logic rf_wr_user,
    output logic [31:0] rf_wr_data,
    output logic status_load,
    output logic mem_req,
    output logic mem_write,
    output logic mem_byte,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_abort,
    output logic mem_lock,
    output logic [1:0] mem_cyc,
    output logic irq_inhibit,
    output logic data_abort_trap,
    output logic instr_done,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ==========================================================
    // State
    btsu_pkg::btsu_state_t state_r; // Sequencer state
    logic load_r; // Load-multiple when set
    logic pre_r; // Adjust address before transfer
    logic up_r; // Ascending addresses
    logic wb_r; // Base write-back requested
    logic sbit_r; // User bank bit, or byte bit for swap
    logic user_r; // Transfers go to the user bank
    logic pcin_r; // Program counter in the list
    logic [4:0] n_r; // Words in the list
    logic [4:0] cnt_r; // Transfers still in flight
    logic [15:0] pend_r; // Registers not yet moved
    logic [3:0] dest_r; // Swap destination
    logic [31:0] orig_base_r; // Base before the instruction
    logic [31:0] new_base_r; // Base after write-back
    logic [31:0] hold_r; // Old memory value during swap
    logic [31:0] iaddr_r; // Instruction address
    logic abt_r; // Abort seen in this instruction
    logic [7:0] cyc_cnt_r; // Cycles spent so far
    logic ctrl_en_r; // Software enable
    logic big_r; // Big-endian lanes for byte swap
    logic st_abort_r; // Last instruction trapped
    logic st_bad_r; // Last word was not handled here
    logic [7:0] last_cyc_r; // Cycle count of last instruction
    logic swap_sel_r; // Current instruction is a swap
    // ==========================================================
    // Decode and datapath
    wire logic accept = instr_valid && instr_ready;
    wire logic is_blk = instr_word[27:25] == `BTSU_BLK_CLASS;
    wire logic is_swp = instr_word[27:23] == `BTSU_SWP_CLASS && instr_word[21:20] == 2'b00
        && instr_word[11:4] == `BTSU_SWP_MARK;
    wire logic [15:0] rd_bit = 16'h0001 << rf_rd_idx;
    // Next register to move is the lowest one left
    wire logic [15:0] pend_nxt = (state_r == btsu_pkg::ST_IDLE) ? instr_word[15:0]
        : (pend_r & ~rd_bit);
    wire logic [3:0] low_idx;
    wire logic [4:0] nwords;
    wire logic [31:0] span = {25'h0000000, n_r, 2'b00};
    // Start address and written-back base per mode
    wire logic [31:0] start_addr = up_r ? rf_base_data + (pre_r ? `BTSU_WORD_STEP : 32'h0)
        : rf_base_data - span + (pre_r ? 32'h0 : `BTSU_WORD_STEP);
    wire logic [31:0] base_nxt = up_r ? rf_base_data + span : rf_base_data - span;
    // Base stored first is old, later positions see new value
    wire logic base_fwd = rf_rd_idx == rf_base_idx && wb_r && state_r != btsu_pkg::ST_CALC;
    wire logic [31:0] store_data = (rf_rd_idx == `BTSU_PC_IDX) ? iaddr_r + `BTSU_PC_STORE_OFS
        : (base_fwd ? new_base_r : rf_rd_data);
    wire logic abort_now = mem_req && mem_abort;
    wire logic abt_any = abt_r || abort_now;
    // Byte lane follows the configured endianness
    wire logic [1:0] lane = big_r ? ~mem_addr[1:0] : mem_addr[1:0];
    wire logic [7:0] rbyte = mem_rdata[{lane, 3'b000} +: 8];
    wire logic [31:0] swap_val = sbit_r ? {24'h000000, rbyte} : mem_rdata;
    wire logic [31:0] restore = wb_r ? new_base_r : orig_base_r;
    wire logic [31:0] next_addr = mem_addr + `BTSU_WORD_STEP;

    btsu_lowbit #(.WIDTH(16)) u_lowbit (
        .mask(pend_nxt),
        .index(low_idx)
    );

    btsu_popcnt #(.WIDTH(16)) u_popcnt (
        .mask(instr_word[15:0]),
        .count(nwords)
    );

    // ==========================================================
    // Sequencer
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= btsu_pkg::ST_IDLE;
            {load_r, pre_r, up_r, wb_r, sbit_r, user_r, pcin_r, abt_r} <= 8'h00;
            {n_r, cnt_r} <= 10'h000;
            pend_r <= 16'h0000;
            dest_r <= 4'h0;
            {orig_base_r, new_base_r, hold_r, iaddr_r} <= 128'h0;
            {rf_rd_idx, rf_base_idx, rf_wr_idx} <= 12'h000;
            {rf_rd_user, rf_wr_en, rf_wr_user, status_load} <= 4'h0;
            rf_wr_data <= 32'h00000000;
            {mem_req, mem_write, mem_byte, mem_lock} <= 4'h0;
            {mem_addr, mem_wdata} <= 64'h0;
            mem_cyc <= btsu_pkg::CYC_I;
            {irq_inhibit, data_abort_trap, instr_done, instr_ready} <= 4'h0;
            {st_abort_r, st_bad_r} <= 2'h0;
            {cyc_cnt_r, last_cyc_r} <= 16'h0000;
        end else begin
            // Pulses and one-shot writes fall back by default
            rf_wr_en <= 1'b0;
            status_load <= 1'b0;
            data_abort_trap <= 1'b0;
            instr_done <= 1'b0;
            instr_ready <= 1'b0;
            cyc_cnt_r <= cyc_cnt_r + 8'h01;
            case (state_r)
                btsu_pkg::ST_IDLE: begin
                    cyc_cnt_r <= 8'h00;
                    instr_ready <= ctrl_en_r && !accept;
                    if (accept) begin
                        iaddr_r <= instr_addr;
                        pre_r <= instr_word[`BTSU_P_BIT];
                        up_r <= instr_word[`BTSU_U_BIT];
                        sbit_r <= instr_word[`BTSU_S_BIT];
                        wb_r <= instr_word[`BTSU_W_BIT] && is_blk;
                        load_r <= instr_word[`BTSU_L_BIT];
                        n_r <= nwords;
                        pcin_r <= instr_word[15];
                        abt_r <= 1'b0;
                        rf_base_idx <= instr_word[19:16];
                        if (is_blk) begin
                            // User bank when the S bit is set, unless a load also takes the PC
                            user_r <= instr_word[`BTSU_S_BIT]
                                && !(instr_word[`BTSU_L_BIT] && instr_word[15]);
                            rf_rd_user <= instr_word[`BTSU_S_BIT]
                                && !(instr_word[`BTSU_L_BIT] && instr_word[15]);
                            rf_rd_idx <= low_idx;
                            pend_r <= instr_word[15:0];
                            mem_cyc <= btsu_pkg::CYC_N;
                            irq_inhibit <= 1'b1;
                            state_r <= btsu_pkg::ST_CALC;
                        end else if (is_swp) begin
                            user_r <= 1'b0;
                            rf_rd_user <= 1'b0;
                            rf_rd_idx <= instr_word[3:0];
                            dest_r <= instr_word[15:12];
                            mem_cyc <= btsu_pkg::CYC_S;
                            irq_inhibit <= 1'b1;
                            state_r <= btsu_pkg::ST_CALC;
                        end else begin
                            // Not ours: retire at once and flag it
                            st_bad_r <= 1'b1;
                            instr_done <= 1'b1;
                        end
                    end
                end
                btsu_pkg::ST_CALC: begin
                    orig_base_r <= rf_base_data;
                    new_base_r <= base_nxt;
                    mem_req <= 1'b1;
                    if (is_swp_r()) begin
                        // Read the base address first, under lock
                        mem_addr <= rf_base_data;
                        mem_write <= 1'b0;
                        mem_byte <= sbit_r;
                        mem_lock <= 1'b1;
                        mem_wdata <= sbit_r ? {4{rf_rd_data[7:0]}} : rf_rd_data;
                        mem_cyc <= btsu_pkg::CYC_N;
                        state_r <= btsu_pkg::ST_SWRD;
                    end else begin
                        mem_addr <= start_addr;
                        mem_write <= !load_r;
                        mem_byte <= 1'b0;
                        mem_wdata <= store_data;
                        // Store issues its first word now; loads use data later
                        mem_cyc <= load_r ? btsu_pkg::CYC_S : btsu_pkg::CYC_N;
                        cnt_r <= n_r;
                        if (!load_r) begin
                            pend_r <= pend_nxt;
                            rf_rd_idx <= low_idx;
                        end
                        // Write-back lands at the end of the second cycle
                        rf_wr_en <= wb_r;
                        rf_wr_idx <= rf_base_idx;
                        rf_wr_user <= 1'b0;
                        rf_wr_data <= base_nxt;
                        state_r <= btsu_pkg::ST_XFER;
                    end
                end
                btsu_pkg::ST_XFER: begin
                    abt_r <= abt_any;
                    cnt_r <= cnt_r - 5'h01;
                    mem_cyc <= btsu_pkg::CYC_S;
                    mem_addr <= next_addr;
                    pend_r <= pend_nxt;
                    rf_rd_idx <= low_idx;
                    if (load_r) begin
                        // Loaded base wins over write-back; abort stops writes
                        rf_wr_en <= !abt_any;
                        rf_wr_idx <= rf_rd_idx;
                        rf_wr_user <= user_r;
                        rf_wr_data <= mem_rdata;
                        // Status copied with the PC load
                        status_load <= !abt_any && sbit_r && rf_rd_idx == `BTSU_PC_IDX;
                        if (cnt_r == 5'h01) begin
                            mem_req <= 1'b0;
                            mem_cyc <= btsu_pkg::CYC_I;
                            if (abt_any) begin
                                // Slot of the lost load restores the base
                                rf_wr_en <= 1'b1;
                                rf_wr_idx <= rf_base_idx;
                                rf_wr_user <= 1'b0;
                                rf_wr_data <= restore;
                            end
                            state_r <= btsu_pkg::ST_FIN;
                        end
                    end else begin
                        // Stores run on through an abort
                        mem_wdata <= store_data;
                        if (cnt_r == 5'h01) begin
                            mem_req <= 1'b0;
                            mem_write <= 1'b0;
                            mem_cyc <= btsu_pkg::CYC_I;
                            finish(abt_any);
                        end
                    end
                end
                btsu_pkg::ST_FIN: begin
                    if (pcin_r && !abt_r) begin
                        // Refill after a PC load
                        mem_cyc <= btsu_pkg::CYC_S;
                        state_r <= btsu_pkg::ST_PCF1;
                    end else begin
                        finish(abt_r);
                    end
                end
                btsu_pkg::ST_PCF1: begin
                    mem_cyc <= btsu_pkg::CYC_N;
                    state_r <= btsu_pkg::ST_PCF2;
                end
                btsu_pkg::ST_PCF2: begin
                    mem_cyc <= btsu_pkg::CYC_I;
                    finish(abt_r);
                end
                btsu_pkg::ST_SWRD: begin
                    // Read cycle: keep old value, go straight to the write
                    abt_r <= abt_any;
                    hold_r <= swap_val;
                    mem_write <= 1'b1;
                    state_r <= btsu_pkg::ST_SWWR;
                end
                btsu_pkg::ST_SWWR: begin
                    abt_r <= abt_any;
                    // Lock falls as the write completes
                    mem_lock <= 1'b0;
                    mem_req <= 1'b0;
                    mem_write <= 1'b0;
                    mem_cyc <= btsu_pkg::CYC_I;
                    rf_wr_en <= !abt_any;
                    rf_wr_idx <= dest_r;
                    rf_wr_user <= 1'b0;
                    rf_wr_data <= hold_r;
                    state_r <= btsu_pkg::ST_SWFIN;
                end
                btsu_pkg::ST_SWFIN: begin
                    finish(abt_r);
                end
                default: begin
                    state_r <= btsu_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Swap flag is captured at the take, so stale list fields never steer CALC
    function automatic logic is_swp_r();
        return swap_sel_r;
    endfunction : is_swp_r

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            swap_sel_r <= 1'b0;
        end else if (accept) begin
            swap_sel_r <= is_swp && !is_blk;
        end
    end

    // Common ending: report, trap if needed, return to idle
    task automatic finish(input logic trap);
        state_r <= btsu_pkg::ST_IDLE;
        instr_done <= 1'b1;
        data_abort_trap <= trap;
        st_abort_r <= trap;
        st_bad_r <= 1'b0;
        last_cyc_r <= cyc_cnt_r + 8'h01;
        irq_inhibit <= 1'b0;
        instr_ready <= ctrl_en_r;
    endtask : finish

    // ==========================================================
    // Register bus: write channel, address and data taken together
    wire logic wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    wire logic wr_ctrl = s_axi_awaddr == `BTSU_CTRL_OFS;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            {s_axi_awready, s_axi_wready, s_axi_bvalid} <= 3'h0;
            s_axi_bresp <= `BTSU_RESP_OKAY;
            {big_r, ctrl_en_r} <= `BTSU_CTRL_RESET;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ctrl || s_axi_awaddr == `BTSU_STATUS_OFS
                    || s_axi_awaddr == `BTSU_CYCLES_OFS ? `BTSU_RESP_OKAY : `BTSU_RESP_DECERR;
                if (wr_ctrl && s_axi_wstrb[0]) begin
                    ctrl_en_r <= s_axi_wdata[`BTSU_CTRL_EN_BIT];
                    big_r <= s_axi_wdata[`BTSU_CTRL_BIG_BIT];
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Register bus: read channel
    wire logic rd_go = s_axi_arready && s_axi_arvalid;
    wire logic [31:0] rd_mux = (s_axi_araddr == `BTSU_CTRL_OFS) ? {30'h0, big_r, ctrl_en_r}
        : (s_axi_araddr == `BTSU_STATUS_OFS)
            ? {29'h0, st_bad_r, st_abort_r, state_r != btsu_pkg::ST_IDLE}
        : (s_axi_araddr == `BTSU_CYCLES_OFS) ? {24'h000000, last_cyc_r} : 32'h00000000;
    wire logic rd_hit = s_axi_araddr == `BTSU_CTRL_OFS || s_axi_araddr == `BTSU_STATUS_OFS
        || s_axi_araddr == `BTSU_CYCLES_OFS;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            {s_axi_arready, s_axi_rvalid} <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BTSU_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `BTSU_RESP_OKAY : `BTSU_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : btsu_core
`default_nettype wire

// ---- testbench/btsu_mem_model.sv ----
// Zero-wait memory with address-matched aborts for the transfer unit
`timescale 1ns/100ps
`default_nettype none
module btsu_mem_model (
    input wire logic clock,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] abort_addr,
    input wire logic [1:0] abort_on,
    output logic [31:0] mem_rdata,
    output logic mem_abort
);
    // ==========
    // Storage
    logic [31:0] mem [0:63]; // Word array, loaded by the bench
    logic [31:0] junk_r = 32'h5A5A5A5A; // Flips each cycle so idle data never looks valid
    logic mute_r = 1'h0; // Blocks writes once a burst has aborted
    // Bit 0 of abort_on aborts reads, bit 1 writes, at one address
    assign mem_abort = mem_req && mem_addr == abort_addr && abort_on[mem_write];
    assign mem_rdata = mem_req ? mem[mem_addr[7:2]] : junk_r;
    // Writes land unless aborted or muted after an abort; the bus is never taken away
    always @(posedge clock) begin
        junk_r <= ~junk_r;
        mute_r <= mem_req && (mute_r || mem_abort);
        if (mem_req && mem_write && !mem_abort && !mute_r) mem[mem_addr[7:2]] <= mem_wdata;
    end
endmodule : btsu_mem_model
`default_nettype wire

// ---- testbench/btsu_monitor.sv ----
// Checker for swap locking, traps and take timing
`timescale 1ns/100ps
`default_nettype none
module btsu_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic mem_abort,
    input wire logic mem_lock,
    input wire logic [1:0] mem_cyc,
    input wire logic irq_inhibit,
    input wire logic data_abort_trap,
    input wire logic instr_done
);
    // ==========
    // Swap steps, trap completion and take timing
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence swap_rd; mem_lock && mem_req && !mem_write; endsequence
    sequence swap_wr; mem_lock && mem_req && mem_write; endsequence
    AST_LOCK_PAIR: assert property (swap_rd |=> swap_wr)
        else $error("locked read not followed by write");
    AST_LOCK_DROP: assert property (swap_wr |=> !mem_lock)
        else $error("lock held past write");
    AST_LOCK_NCYC: assert property (mem_lock |-> mem_req && mem_cyc == 2'h0)
        else $error("lock outside an N transfer");
    AST_LOCK_IRQ: assert property (mem_lock |-> irq_inhibit)
        else $error("interrupts open during lock");
    AST_SWAP_TIME: assert property (swap_rd |-> ##3 instr_done)
        else $error("swap length wrong");
    AST_SWAP_TRAP: assert property (mem_lock && mem_abort |-> ##[2:3] data_abort_trap)
        else $error("swap abort without trap");
    AST_TRAP_DONE: assert property (data_abort_trap |-> instr_done)
        else $error("trap before completion");
    AST_TAKE_IDLE: assert property (instr_valid && instr_ready |=> !instr_ready && !mem_req)
        else $error("transfer in first cycle");
endmodule : btsu_monitor
bind btsu_core btsu_monitor u_mon (.*);
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the transfer and swap unit
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ==========
    // Signals
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic instr_valid = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] instr_word = 32'h0, instr_addr = 32'h0, s_axi_wdata = 32'h0, abort_addr = 32'h1;
    logic [1:0] abort_on = 2'h3, s_axi_rresp, s_axi_bresp;
    logic instr_ready, rf_wr_en, mem_req, mem_write, mem_abort, data_abort_trap, instr_done;
    logic s_axi_awready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, s_axi_wready;
    logic [3:0] rf_rd_idx, rf_base_idx, rf_wr_idx;
    logic [31:0] rf_wr_data, mem_addr, mem_wdata, mem_rdata, s_axi_rdata, keep, hold;
    logic [31:0] rf [0:15]; // Register bank seen by the unit
    logic [32:0] notes [$]; // Trap flag and cycle count per instruction
    logic [32:0] note;
    int seed = 32'hD639;
    int fails = 0, samples_checked = 0, ticks = 0, cyc = 0;
    int off [4] = '{0, 0, -4, 4}; // Single-word offset per mode
    always #10 clock = ~clock;
    btsu_core u_dut (.*, .rf_rd_user(), .rf_wr_user(), .status_load(), .mem_byte(), .mem_lock(),
        .mem_cyc(), .irq_inhibit(), .s_axi_wstrb(4'hF),
        .rf_rd_data(rf[rf_rd_idx]), .rf_base_data(rf[rf_base_idx]));
    btsu_mem_model u_mem (.*);
    always @(posedge clock) if (rf_wr_en === 1'h1) rf[rf_wr_idx] <= rf_wr_data;
    // Oldest note against each retirement; hang guard
    always @(posedge clock) begin
        if (instr_done === 1'h1) begin
            note = notes.pop_front();
            check("trap", 32'(data_abort_trap), 32'(note[32]));
            check("cycles", 32'(cyc), note[31:0]);
        end
        cyc = (instr_valid && instr_ready) ? 0 : cyc + 1;
        ticks = ticks + 1;
        if (ticks == 2000) begin
            fails = fails + 1;
            complete_run();
        end
    end
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked = samples_checked + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic complete_run();
        $display("Compared %0d, mismatched %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic run(input logic [31:0] w, input logic t, input int c);
        notes.push_back({t, 32'(c)});
        instr_addr <= $random(seed) & 32'hFFFFFFFC;
        instr_word <= w;
        instr_valid <= 1'h1;
        do @(posedge clock); while (instr_ready !== 1'h1);
        instr_valid <= 1'h0;
        do @(posedge clock); while (instr_done !== 1'h1);
        $display("Instruction %h finished", w);
    endtask : run
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw = 1'h1, w = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (aw || w) begin
            @(posedge clock);
            aw = aw && s_axi_awready !== 1'h1;
            w = w && s_axi_wready !== 1'h1;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do @(posedge clock); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        check("bresp", 32'(s_axi_bresp), 32'h0);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clock); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge clock); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        check("rdata", s_axi_rdata, e);
        check("rresp", 32'(s_axi_rresp), 32'(r));
    endtask : axi_rd
    // ==========
    // Main sequence
    initial begin
        for (int i = 0; i < 64; i++) u_mem.mem[i] = $random(seed);
        for (int i = 0; i < 16; i++) rf[i] = $random(seed);
        repeat (3) @(posedge clock);
        sys_rst <= 1'h0;
        @(posedge clock);
        axi_rd(8'h00, 32'h1, 2'h0);
        axi_rd(8'hFC, 32'h0, 2'h3);
        axi_wr(8'h00, 32'h3);
        axi_rd(8'h00, 32'h3, 2'h0);
        for (int m = 0; m < 4; m++) begin
            rf[1] = $random(seed);
            rf[2] = 32'h80;
            run(32'hE8020002 | (32'(m) << 23), 1'h0, 2);
            check("mode", u_mem.mem[(32'h80 + off[m]) >> 2], rf[1]);
            check("base_kept", rf[2], 32'h80);
        end
        rf[3] = 32'h80;
        run(32'hE8A3800A, 1'h0, 4);
        check("late_base", u_mem.mem[33], 32'h8C);
        check("pc_word", u_mem.mem[34], instr_addr + 32'hC);
        check("wb_base", rf[3], 32'h8C);
        rf[3] = 32'h80;
        run(32'hE8930018, 1'h0, 4);
        check("load_base", rf[3], u_mem.mem[32]);
        rf[3] = 32'h80;
        rf[4] = 32'h0;
        abort_addr <= 32'h84;
        run(32'hE8B30038, 1'h1, 5);
        check("abt_base", rf[3], 32'h8C);
        check("abt_stop", rf[4], 32'h0);
        rf[3] = 32'h80;
        abort_addr <= 32'h80;
        run(32'hE8A30030, 1'h1, 3);
        check("abt_wb", rf[3], 32'h88);
        run(32'hE8D38008, 1'h0, 6);
        check("pc_load", rf[15], u_mem.mem[35]);
        for (int k = 0; k < 4; k++) begin
            rf[1] = $random(seed);
            keep = u_mem.mem[32];
            hold = rf[0];
            abort_on <= 2'(k);
            run(32'hE1020091, k != 0, 4);
            check("swap_dest", rf[0], (k != 0) ? hold : keep);
            if (k == 0) check("swap_mem", u_mem.mem[32], rf[1]);
        end
        axi_rd(8'h08, 32'h4, 2'h0);
        complete_run();
    end
endmodule : tb
`default_nettype wire
